// file: verilog/hhcs_config_select.v
// Purpose: host or hardware configuration source, serial port, datapath
// Assumes: pins are asynchronous; terminal and slicer logic on sys_clk
// Notes:   serial clock is oversampled; it must stay well below sys_clk/4
`timescale 1ns/1ps
`include "hhcs_regs.vh"

// Operation
// - Select pin low gives hardware mode
// - Hardware mode disables serial port, uses pins
// - Select pin high gives host mode
// - Host mode configures from serial command registers
// - Serial pins take alternate hardware roles
// - Hardware mode honours all per-channel pins
// - Host mode ignores per-channel pins except driver-off; tie low
// - Host mode driver-off pins switch all channels
// - B3ZS for DS3/STS-1, HDB3 for E3
// - Mark is one pulse, space none
// - Transmit accepts single or dual rail
// - Receive outputs positive, negative data, clock
// - Each channel rate set independently
// - One serial port shared by all channels
// - Serial input sampled on rising clock
// - Serial output changes on falling clock
// - Serial output released when select high
// - Read/write bit one reads, zero writes
// - Command register fields default to zero
module hhcs_config_select #(
   parameter NCH = 4
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             rst_n,
   // Mode strap
   input  wire             configSourceSelect,
   // Shared serial port pins, dual use
   input  wire             chipSelectPin,
   input  wire             serialClockPin,
   input  wire             serialIn,
   input  wire             serialOutPin,
   output reg              serialOut,
   output wire             serialOutOe,
   input  wire             registerResetPin,
   // Hardware mode per-channel pins
   input  wire [NCH-1:0]   txOutputLevelSelect,
   input  wire [NCH-1:0]   txAllOnesSend,
   input  wire [NCH-1:0]   rxEqualizerEnable,
   input  wire [NCH-1:0]   remoteLoopback,
   input  wire [NCH-1:0]   localLoopback,
   input  wire [NCH-1:0]   sonetVsT3Select,
   input  wire [1:0]       eRateSelect,
   input  wire [NCH-1:0]   txDriverOff,
   // Channel status for the read-only register
   input  wire [5*NCH-1:0] chanStatus,
   // Terminal transmit side
   input  wire [NCH-1:0]   txBitStrobe,
   input  wire [NCH-1:0]   txPosIn,
   input  wire [NCH-1:0]   txNegIn,
   // Receiver slicer side
   input  wire [NCH-1:0]   rxSlicePos,
   input  wire [NCH-1:0]   rxSliceNeg,
   input  wire [NCH-1:0]   rxSliceClk,
   // Line transmit rails
   output reg  [NCH-1:0]   txLinePos,
   output reg  [NCH-1:0]   txLineNeg,
   // Terminal receive side
   output reg  [NCH-1:0]   rxPosData,
   output reg  [NCH-1:0]   rxNegData,
   output reg  [NCH-1:0]   rxRecoveredClock,
   // Resolved configuration
   output reg              hostMode,
   output reg  [NCH-1:0]   cfgRateE3,
   output reg  [NCH-1:0]   cfgRateSonet,
   output reg  [NCH-1:0]   cfgTxLevel,
   output reg  [NCH-1:0]   cfgAllOnes,
   output reg  [NCH-1:0]   cfgEqEnable,
   output reg  [NCH-1:0]   cfgRxPowerDown,
   output reg  [NCH-1:0]   cfgRxClkInvert,
   output reg  [NCH-1:0]   cfgSingleRail,
   output reg  [NCH-1:0]   cfgLocalLb,
   output reg  [NCH-1:0]   cfgRemoteLb,
   output reg  [NCH-1:0]   cfgTxOff
);

   // Synchroniser stages
   reg             selMeta_q;
   reg             selSync_q;
   reg             csMeta_q;
   reg             cs_q;
   reg             sclkMeta_q;
   reg             sclk_q;
   reg             sclkPrev_q;
   reg             sdiMeta_q;
   reg             sdi_q;
   reg             sdoMeta_q;
   reg             sdoPin_q;
   reg             regrMeta_q;
   reg             register_reset_pin_q;
   reg [NCH-1:0]   levMeta_q;
   reg [NCH-1:0]   lev_q;
   reg [NCH-1:0]   aosMeta_q;
   reg [NCH-1:0]   aos_q;
   reg [NCH-1:0]   eqMeta_q;
   reg [NCH-1:0]   eq_q;
   reg [NCH-1:0]   rlbMeta_q;
   reg [NCH-1:0]   rlb_q;
   reg [NCH-1:0]   llbMeta_q;
   reg [NCH-1:0]   llb_q;
   reg [NCH-1:0]   stsMeta_q;
   reg [NCH-1:0]   sts_q;
   reg [1:0]       e3Meta_q;
   reg [1:0]       e3_q;
   reg [NCH-1:0]   offMeta_q;
   reg [NCH-1:0]   off_q;

   // Serial engine state
   reg  [4:0]      bitCnt_q;
   reg  [7:0]      inShift_q;
   reg  [5:0]      addr_q;
   reg             readOp_q;
   reg  [4:0]      rdShift_q;
   reg  [4:0]      cmdReg_q [0:4*NCH-1];
   reg  [4:0]      rdValue;
   wire            sclkRise;
   wire            sclkFall;
   wire            xferActive;
   wire [2:0]      regSel;
   wire [1:0]      chSel;
   wire [2:0]      regOff;
   wire [5:0]      wrAddr;
   wire [4:0]      wrData;
   wire            wrHit;
   wire [NCH-1:0]  e3Hw;
   wire [NCH-1:0]  encPos;
   wire [NCH-1:0]  encNeg;
   integer         i;

   // Two-stage synchronisers for the strap, serial and hardware configuration pins
   always @(posedge sys_clk) begin
      selMeta_q  <= configSourceSelect;
      selSync_q  <= selMeta_q;
      csMeta_q   <= chipSelectPin;
      cs_q       <= csMeta_q;
      sclkMeta_q <= serialClockPin;
      sclk_q     <= sclkMeta_q;
      sclkPrev_q <= sclk_q;
      sdiMeta_q  <= serialIn;
      sdi_q      <= sdiMeta_q;
      sdoMeta_q  <= serialOutPin;
      sdoPin_q   <= sdoMeta_q;
      regrMeta_q <= registerResetPin;
      register_reset_pin_q     <= regrMeta_q;
      levMeta_q  <= txOutputLevelSelect;
      lev_q      <= levMeta_q;
      aosMeta_q  <= txAllOnesSend;
      aos_q      <= aosMeta_q;
      eqMeta_q   <= rxEqualizerEnable;
      eq_q       <= eqMeta_q;
      rlbMeta_q  <= remoteLoopback;
      rlb_q      <= rlbMeta_q;
      llbMeta_q  <= localLoopback;
      llb_q      <= llbMeta_q;
      stsMeta_q  <= sonetVsT3Select;
      sts_q      <= stsMeta_q;
      e3Meta_q   <= eRateSelect;
      e3_q       <= e3Meta_q;
      offMeta_q  <= txDriverOff;
      off_q      <= offMeta_q;
   end

   // Mode follows the strap: low hardware, high host
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         hostMode <= 1'b0;
      end else begin
         hostMode <= selSync_q;
      end
   end

   // Serial clock edges and frame qualifier
   assign sclkRise   = sclk_q & ~sclkPrev_q;
   assign sclkFall   = ~sclk_q & sclkPrev_q;
   assign xferActive = hostMode & ~cs_q;

   // Address decode: channel in bits 4:3, register in bits 2:0
   assign wrAddr = {sdi_q, inShift_q[7:3]};
   assign regSel = addr_q[2:0];
   assign chSel  = addr_q[4:3];
   assign regOff = regSel - `HHCS_CR_TX;
   assign wrData = inShift_q[5:1];
   assign wrHit  = (regSel >= `HHCS_CR_TX) && (regSel <= `HHCS_CR_RATE)
                   && !addr_q[5];

   // Bit counter, shifter and read/write capture
   always @(posedge sys_clk) begin
      if (!rst_n || !xferActive) begin
         bitCnt_q  <= `HHCS_CNT_ZERO;
         inShift_q <= 8'h00;
         readOp_q  <= 1'b0;
      end else if (sclkRise) begin
         inShift_q <= {sdi_q, inShift_q[7:1]};
         if (bitCnt_q != `HHCS_CNT_DONE) begin
            bitCnt_q <= bitCnt_q + 5'h01;
         end
         if (bitCnt_q == `HHCS_CNT_RW) begin
            readOp_q <= sdi_q;
         end
      end
   end

   // Address latch at the last address bit
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_q <= 6'h00;
      end else if (xferActive && sclkRise && bitCnt_q == `HHCS_CNT_A5) begin
         addr_q <= wrAddr;
      end
   end

   // Read source: status, command register, or zero
   always @* begin
      rdValue = 5'h00;
      if (regSel == `HHCS_CR_STATUS) begin
         rdValue = chanStatus[5 * chSel +: 5];
      end else if (wrHit) begin
         rdValue = cmdReg_q[{chSel, regOff[1:0]}];
      end
   end

   // Command registers, written on the last data bit
   always @(posedge sys_clk) begin
      if (!rst_n || (hostMode && !register_reset_pin_q)) begin
         for (i = 0; i < 4 * NCH; i = i + 1) begin
            cmdReg_q[i] <= `HHCS_CR_RST;
         end
      end else if (xferActive && sclkRise && bitCnt_q == `HHCS_CNT_LAST
                   && !readOp_q && wrHit) begin
         // Data arrives D0 first; keep D4..D0
         cmdReg_q[{chSel, regOff[1:0]}] <= wrData;
      end
   end

   // Read data shifted out on falling serial clock edges
   always @(posedge sys_clk) begin
      if (!rst_n || !xferActive) begin
         rdShift_q <= 5'h00;
         serialOut <= 1'b0;
      end else if (sclkRise && bitCnt_q == `HHCS_CNT_DUMMY) begin
         rdShift_q <= rdValue;
      end else if (sclkFall && readOp_q && bitCnt_q >= `HHCS_CNT_DATA) begin
         serialOut <= rdShift_q[0];
         rdShift_q <= {1'b0, rdShift_q[4:1]};
      end
   end

   // Drive only during the data phase of a read
   assign serialOutOe = xferActive & readOp_q
                        & (bitCnt_q > `HHCS_CNT_DATA);

   // Serial data pins double as rate selects for channels 0 and 1
   assign e3Hw = {e3_q, sdi_q, sdoPin_q};

   // Per-channel configuration, datapath and loopbacks
   genvar n;
   generate
      for (n = 0; n < NCH; n = n + 1) begin : gChan
         // Resolve each channel on its own source
         always @(posedge sys_clk) begin
            if (!rst_n) begin
               cfgRateE3[n]      <= 1'b0;
               cfgRateSonet[n]   <= 1'b0;
               cfgTxLevel[n]     <= 1'b0;
               cfgAllOnes[n]     <= 1'b0;
               cfgEqEnable[n]    <= 1'b0;
               cfgRxPowerDown[n] <= 1'b0;
               cfgRxClkInvert[n] <= 1'b0;
               cfgSingleRail[n]  <= 1'b0;
               cfgLocalLb[n]     <= 1'b0;
               cfgRemoteLb[n]    <= 1'b0;
               cfgTxOff[n]       <= 1'b0;
            end else if (hostMode) begin
               // Pins other than driver-off are ignored here
               cfgRateE3[n]      <= cmdReg_q[4*n+3][`HHCS_F_E3];
               cfgRateSonet[n]   <= cmdReg_q[4*n+3][`HHCS_F_STS];
               cfgLocalLb[n]     <= cmdReg_q[4*n+3][`HHCS_F_LLB];
               cfgRemoteLb[n]    <= cmdReg_q[4*n+3][`HHCS_F_RLB];
               cfgTxLevel[n]     <= cmdReg_q[4*n][`HHCS_F_TXLEV];
               cfgAllOnes[n]     <= cmdReg_q[4*n][`HHCS_F_AOS];
               cfgEqEnable[n]    <= cmdReg_q[4*n+1][`HHCS_F_EQEN];
               cfgRxPowerDown[n] <= cmdReg_q[4*n+2][`HHCS_F_RECEIVER_POWER_DOWN];
               cfgRxClkInvert[n] <= cmdReg_q[4*n+2][`HHCS_F_RXINV];
               cfgSingleRail[n]  <= cmdReg_q[4*n+2][`HHCS_F_RAIL];
               // Any driver-off pin silences every channel together
               cfgTxOff[n] <= (|off_q) | cmdReg_q[4*n][`HHCS_F_TX_DRIVER_OFF];
            end else begin
               cfgRateE3[n]      <= e3Hw[n];
               cfgRateSonet[n]   <= sts_q[n];
               cfgLocalLb[n]     <= llb_q[n];
               cfgRemoteLb[n]    <= rlb_q[n];
               cfgTxLevel[n]     <= lev_q[n];
               cfgAllOnes[n]     <= aos_q[n];
               cfgEqEnable[n]    <= eq_q[n];
               cfgRxPowerDown[n] <= sclk_q;
               cfgRxClkInvert[n] <= register_reset_pin_q;
               cfgSingleRail[n]  <= cs_q;
               cfgTxOff[n]       <= off_q[n];
            end
         end

         // Channel line encoder
         hhcs_line_encoder uEnc (
            .sys_clk    (sys_clk),
            .rst_n      (rst_n),
            .bitStrobe  (txBitStrobe[n]),
            .dataIn     (txPosIn[n]),
            .negIn      (txNegIn[n]),
            .singleRail (cfgSingleRail[n]),
            .rateE3     (cfgRateE3[n]),
            .allOnes    (cfgAllOnes[n]),
            .encPos_q   (encPos[n]),
            .encNeg_q   (encNeg[n])
         );

         // Line drivers with remote loopback and driver-off
         always @(posedge sys_clk) begin
            if (!rst_n || cfgTxOff[n]) begin
               txLinePos[n] <= 1'b0;
               txLineNeg[n] <= 1'b0;
            end else if (cfgRemoteLb[n]) begin
               txLinePos[n] <= rxSlicePos[n];
               txLineNeg[n] <= rxSliceNeg[n];
            end else begin
               txLinePos[n] <= encPos[n];
               txLineNeg[n] <= encNeg[n];
            end
         end

         // Terminal receive outputs with local loopback
         always @(posedge sys_clk) begin
            if (!rst_n || cfgRxPowerDown[n]) begin
               rxPosData[n]        <= 1'b0;
               rxNegData[n]        <= 1'b0;
               rxRecoveredClock[n] <= 1'b0;
            end else begin
               rxPosData[n] <= cfgLocalLb[n] ? encPos[n] : rxSlicePos[n];
               rxNegData[n] <= cfgLocalLb[n] ? encNeg[n] : rxSliceNeg[n];
               rxRecoveredClock[n] <= rxSliceClk[n] ^ cfgRxClkInvert[n];
            end
         end
      end
   endgenerate

endmodule // hhcs_config_select

// file: inc/hhcs_regs.vh
// Purpose: constants for the host/hardware configuration select block
// Assumes: included by bare name from the design files
// Notes:   command register fields are five bits wide, D4..D0
`ifndef HHCS_REGS_VH
`define HHCS_REGS_VH

// Command register index within a channel (address bits 2:0)
`define HHCS_CR_STATUS 3'h0
`define HHCS_CR_TX     3'h1
`define HHCS_CR_RATE   3'h4

// Transmit control register fields
`define HHCS_F_TX_DRIVER_OFF   4
`define HHCS_F_AOS     3
`define HHCS_F_TXLEV   1
// Receive equalizer register field
`define HHCS_F_EQEN    0
// Receive control register fields
`define HHCS_F_RAIL    4
`define HHCS_F_RECEIVER_POWER_DOWN   2
`define HHCS_F_RXINV   1
// Rate and loopback register fields
`define HHCS_F_STS     3
`define HHCS_F_E3      2
`define HHCS_F_LLB     1
`define HHCS_F_RLB     0

// Register reset value
`define HHCS_CR_RST    5'h00

// Serial frame positions, counted in rising clock edges from zero
`define HHCS_CNT_ZERO  5'h00
`define HHCS_CNT_RW    5'h00
`define HHCS_CNT_A5    5'h06
`define HHCS_CNT_DUMMY 5'h07
`define HHCS_CNT_DATA  5'h08
`define HHCS_CNT_LAST  5'h0F
`define HHCS_CNT_DONE  5'h10

// Line symbol kinds in the encoder pipe
`define HHCS_SYM_ZERO  2'h0
`define HHCS_SYM_PULSE 2'h1
`define HHCS_SYM_VIOL  2'h2

// Zero run that triggers a substitution
`define HHCS_RUN_B3ZS  3'h3
`define HHCS_RUN_HDB3  3'h4

`endif

// file: verilog/hhcs_line_encoder.v
// Purpose: one channel transmit framing, single or dual rail to line rails
// Assumes: bitStrobe marks one terminal bit, same clock as sys_clk
// Notes:   four symbol pipe delays single-rail data by four bits
`timescale 1ns/1ps
`include "hhcs_regs.vh"

module hhcs_line_encoder (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       rst_n,
   // Terminal side
   input  wire       bitStrobe,
   input  wire       dataIn,
   input  wire       negIn,
   // Configuration
   input  wire       singleRail,
   input  wire       rateE3,
   input  wire       allOnes,
   // Encoded rails
   output reg        encPos_q,
   output reg        encNeg_q
);

   reg  [7:0] pipe_q;
   reg  [7:0] pipe_d;
   reg  [2:0] zeroRun_q;
   reg  [2:0] zeroRun_d;
   reg        oddPulses_q;
   reg        oddPulses_d;
   reg        lastPol_q;
   reg        bitIn;
   reg  [2:0] runLen;
   wire [1:0] oldSym;

   assign oldSym = pipe_q[7:6];

   // Substitution of long zero runs
   always @* begin
      bitIn       = allOnes | dataIn;
      runLen      = rateE3 ? `HHCS_RUN_HDB3 : `HHCS_RUN_B3ZS;
      pipe_d      = {pipe_q[5:0], bitIn ? `HHCS_SYM_PULSE : `HHCS_SYM_ZERO};
      oddPulses_d = oddPulses_q ^ bitIn;
      zeroRun_d   = bitIn ? 3'h0 : zeroRun_q + 3'h1;
      if (!bitIn && zeroRun_d == runLen) begin
         // Odd count since last violation: zeros then V, else B then V
         pipe_d[1:0] = `HHCS_SYM_VIOL;
         pipe_d[2 * (runLen - 3'h1) +: 2] =
            oddPulses_q ? `HHCS_SYM_ZERO : `HHCS_SYM_PULSE;
         zeroRun_d   = 3'h0;
         oddPulses_d = 1'b0;
      end
   end

   // Pipe state and rail drive, one symbol per strobe
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pipe_q      <= 8'h00;
         zeroRun_q   <= 3'h0;
         oddPulses_q <= 1'b0;
         lastPol_q   <= 1'b0;
         encPos_q    <= 1'b0;
         encNeg_q    <= 1'b0;
      end else if (bitStrobe) begin
         if (!singleRail) begin
            // Dual rail passes through; both rails high is no pulse
            encPos_q <= dataIn & ~negIn;
            encNeg_q <= negIn & ~dataIn;
         end else begin
            pipe_q      <= pipe_d;
            zeroRun_q   <= zeroRun_d;
            oddPulses_q <= oddPulses_d;
            case (oldSym)
               `HHCS_SYM_PULSE: begin
                  // Mark alternates polarity
                  encPos_q  <= ~lastPol_q;
                  encNeg_q  <= lastPol_q;
                  lastPol_q <= ~lastPol_q;
               end
               `HHCS_SYM_VIOL: begin
                  // Violation repeats the last polarity
                  encPos_q <= lastPol_q;
                  encNeg_q <= ~lastPol_q;
               end
               default: begin
                  // Space is no pulse
                  encPos_q <= 1'b0;
                  encNeg_q <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // hhcs_line_encoder

// file: tb/hhcs_config_select_assertions.sv
// Purpose: port-level checks for hhcs_config_select
// Assumes: one sys_clk domain, pins pass two sync stages
// Notes:   strap and pin checks wait five edges for settling
`timescale 1ns/1ps

module hhcs_config_select_assertions #(
   parameter NCH = 4
) (
   // Clock and reset
   input wire logic           sys_clk,
   input wire logic           rst_n,
   // Strap and serial pins
   input wire logic           configSourceSelect,
   input wire logic           chipSelectPin,
   input wire logic           serialClockPin,
   input wire logic           serialOutPin,
   input wire logic           serialOutOe,
   input wire logic [NCH-1:0] txDriverOff,
   input wire logic [NCH-1:0] rxSlicePos,
   // Design outputs
   input wire logic [NCH-1:0] txLinePos,
   input wire logic [NCH-1:0] txLineNeg,
   input wire logic [NCH-1:0] rxPosData,
   input wire logic           hostMode,
   input wire logic [NCH-1:0] cfgRateE3,
   input wire logic [NCH-1:0] cfgTxOff,
   input wire logic [NCH-1:0] cfgSingleRail,
   input wire logic [NCH-1:0] cfgRxPowerDown,
   input wire logic [NCH-1:0] cfgLocalLb
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Strap and a pin level held through the sync stages
   sequence hwPin(p);
      (!configSourceSelect && p) [*5];
   endsequence
   sequence hostPin(p);
      (configSourceSelect && p) [*5];
   endsequence
   // Receiver neither looped back nor powered down
   sequence rxLive;
      cfgLocalLb == {NCH{1'h0}} && cfgRxPowerDown == {NCH{1'h0}};
   endsequence

   // Mode follows the strap
   chk_hw_mode_low: assert property (hwPin(1'h1) |=> !hostMode)
      else $error("host mode with strap low");
   chk_host_mode_high: assert property (hostPin(1'h1) |=> hostMode)
      else $error("hardware mode with strap high");
   // Serial output driver
   chk_oe_hw_idle: assert property (!hostMode |-> !serialOutOe)
      else $error("serial output driven in hardware mode");
   chk_oe_cs_release: assert property (chipSelectPin [*6] |-> !serialOutOe)
      else $error("serial output driven after deselect");
   // Alternate pin roles in hardware mode
   chk_hw_rail_pin: assert property (hwPin(chipSelectPin) |=> &cfgSingleRail)
      else $error("rail pin not applied");
   chk_hw_receiver_power_down_pin: assert property (hwPin(serialClockPin) |=> &cfgRxPowerDown)
      else $error("receiver off pin not applied");
   chk_hw_e3_pin: assert property (hwPin(serialOutPin) |=> cfgRateE3[0])
      else $error("channel zero rate pin not applied");
   // Host mode driver off reaches every channel
   chk_host_tx_driver_off: assert property (hostPin(|txDriverOff) |=> &cfgTxOff)
      else $error("driver off not on all channels");
   // One pulse polarity at a time
   chk_rails_apart: assert property ((txLinePos & txLineNeg) == {NCH{1'h0}})
      else $error("both line rails high");
   // Receive data follows the slicer by one cycle
   chk_rx_follow: assert property (rxLive ##1 rxLive |-> rxPosData == $past(rxSlicePos))
      else $error("receive data does not follow slicer");
endmodule // hhcs_config_select_assertions

bind hhcs_config_select hhcs_config_select_assertions #(.NCH(NCH))
   hhcs_config_select_assertions_inst (.*);

// file: tb/hhcs_serial_host.sv
// Purpose: host microprocessor model on the shared serial port
// Assumes: 160 ns serial clock, read flag first, LSB first
// Notes:   serial clock stands low outside frames
`timescale 1ns/1ps

module hhcs_serial_host (
   // Serial port pins
   output logic      chipSelect,
   output logic      serialClock,
   output logic      serialData,
   input  wire logic serialPad,
   input  wire logic serialOutOe
);
   // Idle port: deselected, clock still
   initial begin
      chipSelect = 1'h1;
      serialClock = 1'h0;
      serialData = 1'h0;
   end

   // One frame; fewer than 16 bits abandons it mid-way
   task automatic xfer(input logic rd, input logic [5:0] addr, input logic [7:0] wdat,
                       input int nBits, output logic [7:0] rdat);
      logic [15:0] frame;
      frame = {wdat, 1'h0, addr, rd};
      rdat = 8'h00;
      #37 chipSelect = 1'h0;
      #20;
      for (int i = 0; i < nBits; i++) begin
         serialData = frame[i]; // Stable well around the rise
         #60 serialClock = 1'h1;
         #80 serialClock = 1'h0;
         #20 if (i >= 8) rdat[i-8] = serialOutOe ? serialPad : 1'hx;
      end
      #60 chipSelect = 1'h1;
      serialData = ~serialData; // Released line holds no data
      #300;
   endtask
endmodule // hhcs_serial_host

// file: tb/hhcs_config_select_test.sv
// Purpose: self-checking bench for hhcs_config_select
// Assumes: sys_clk 50 MHz, host model makes the serial clock
// Notes:   pins move one nanosecond after the rising edge
`timescale 1ns/1ps

module hhcs_config_select_test;
   // Stimulus and bookkeeping
   logic        sys_clk, rst_n, configSourceSelect, registerResetPin;
   logic        hwRail, hwRxOff, hwE3Ch1, hwE3Ch0;
   logic [3:0]  txOutputLevelSelect, txAllOnesSend, rxEqualizerEnable, txDriverOff;
   logic [3:0]  remoteLoopback, localLoopback, sonetVsT3Select;
   logic [3:0]  txBitStrobe, txPosIn, txNegIn, rxSlicePos, rxSliceNeg, rxSliceClk;
   logic [1:0]  eRateSelect;
   logic [19:0] chanStatus;
   int          fails, n_compared;
   // Design outputs and shared pins
   wire         chipSelectPin, serialClockPin, serialIn, serialOutPin, serialOut;
   wire         serialOutOe, hostCs, hostSclk, hostSdi, hostMode;
   wire [3:0]   txLinePos, txLineNeg, rxPosData, rxNegData, rxRecoveredClock;
   wire [3:0]   cfgRateE3, cfgRateSonet, cfgTxLevel, cfgAllOnes, cfgEqEnable;
   wire [3:0]   cfgRxPowerDown, cfgRxClkInvert, cfgSingleRail, cfgLocalLb;
   wire [3:0]   cfgRemoteLb, cfgTxOff;

   // Pins carry host signals or hardware levels; idle pad shows a moving level
   assign chipSelectPin = configSourceSelect ? hostCs : hwRail;
   assign serialClockPin = configSourceSelect ? hostSclk : hwRxOff;
   assign serialIn = configSourceSelect ? hostSdi : hwE3Ch1;
   assign serialOutPin = serialOutOe ? serialOut : (configSourceSelect ? ~serialOut : hwE3Ch0);

   hhcs_config_select hhcs_config_select_inst (.*);
   hhcs_serial_host hhcs_serial_host_inst (.chipSelect(hostCs), .serialClock(hostSclk),
      .serialData(hostSdi), .serialPad(serialOutPin), .serialOutOe(serialOutOe));

   // Clock
   initial begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Register access through the host model
   task automatic wr(input logic [5:0] a, input logic [4:0] d);
      logic [7:0] q;
      hhcs_serial_host_inst.xfer(1'h0, a, {3'h0, d}, 16, q);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] q);
      hhcs_serial_host_inst.xfer(1'h1, a, 8'h00, 16, q);
   endtask

   // One terminal bit on all channels, sampled before the next
   task automatic send_bit;
      txBitStrobe = 4'hF;
      step(1);
      txBitStrobe = 4'h0;
      step(3);
   endtask

   task automatic test_defaults;
      logic [7:0] q;
      for (int a = 0; a < 32; a++) begin
         rd(a[5:0], q);
         check("register", (a % 8 == 0) ? {3'h0, chanStatus[5*(a/8) +: 5]} : 8'h00, q);
      end
      $display("test_defaults done");
   endtask

   task automatic test_host_write;
      logic [7:0] q;
      wr(6'h0C, 5'h04);
      wr(6'h14, 5'h08);
      wr(6'h2C, 5'h01);
      wr(6'h1C, 5'h01);
      step(2);
      check("cfgRateE3", 8'h02, {4'h0, cfgRateE3});
      check("cfgRateSonet", 8'h04, {4'h0, cfgRateSonet});
      check("cfgRemoteLb", 8'h08, {4'h0, cfgRemoteLb});
      rd(6'h0C, q);
      check("readback", 8'h04, q);
      $display("test_host_write done");
   endtask

   task automatic test_host_pins;
      {txOutputLevelSelect, txAllOnesSend, rxEqualizerEnable} = 12'hFFF;
      {remoteLoopback, localLoopback, sonetVsT3Select} = 12'hFFF;
      eRateSelect = 2'h3;
      {rxSlicePos, rxSliceNeg, rxSliceClk} = 12'hA53;
      step(8);
      check("level, all ones", 8'h00, {cfgTxLevel, cfgAllOnes});
      check("equalizer, local", 8'h00, {cfgEqEnable, cfgLocalLb});
      check("remote, rate", 8'h82, {cfgRemoteLb, cfgRateE3});
      check("remote line", 8'h80, {txLinePos, txLineNeg});
      check("receive data", 8'hA5, {rxPosData, rxNegData});
      check("receive clock", 8'h03, {4'h0, rxRecoveredClock});
      txDriverOff = 4'h4;
      step(8);
      check("cfgTxOff", 8'h0F, {4'h0, cfgTxOff});
      {txOutputLevelSelect, txAllOnesSend, rxEqualizerEnable, txDriverOff} = 16'h0000;
      {remoteLoopback, localLoopback, sonetVsT3Select, eRateSelect} = 14'h0000;
      $display("test_host_pins done");
   endtask

   task automatic test_abort;
      logic [7:0] q;
      hhcs_serial_host_inst.xfer(1'h0, 6'h01, 8'h18, 12, q);
      check("cfgTxOff", 8'h00, {4'h0, cfgTxOff});
      wr(6'h01, 5'h18);
      check("off, all ones", 8'h11, {cfgTxOff, cfgAllOnes});
      step(1);
      registerResetPin = 1'h0;
      step(8);
      registerResetPin = 1'h1;
      step(8);
      check("cleared", 8'h00, {cfgTxOff, cfgAllOnes});
      $display("test_abort done");
   endtask

   task automatic test_hw_mode;
      configSourceSelect = 1'h0;
      {hwRail, hwRxOff, hwE3Ch1, hwE3Ch0} = 4'hD;
      eRateSelect = 2'h1;
      sonetVsT3Select = 4'h8;
      txOutputLevelSelect = 4'h5;
      rxEqualizerEnable = 4'hC;
      rxSlicePos = 4'hF;
      step(8);
      check("hostMode", 8'h00, {7'h00, hostMode});
      check("serialOutOe", 8'h00, {7'h00, serialOutOe});
      check("cfgRateE3", 8'h05, {4'h0, cfgRateE3});
      check("rail, rx off", 8'hFF, {cfgSingleRail, cfgRxPowerDown});
      check("invert, rx data", 8'hF0, {cfgRxClkInvert, rxPosData});
      check("sonet, level", 8'h85, {cfgRateSonet, cfgTxLevel});
      check("equalizer", 8'h0C, {4'h0, cfgEqEnable});
      $display("test_hw_mode done");
   endtask

   task automatic test_tx_line;
      int marks [4];
      marks = '{0, 0, 0, 0};
      hwRxOff = 1'h0;
      for (int b = 0; b < 36; b++) begin
         send_bit;
         for (int c = 0; c < 4 && b >= 12; c++)
            marks[c] += (txLinePos[c] | txLineNeg[c]) ? 1 : 0;
      end
      for (int c = 0; c < 4; c++)
         check("marks", (c % 2) ? 8'h10 : 8'h0C, 8'(marks[c]));
      hwRail = 1'h0;
      step(8);
      {txPosIn, txNegIn} = 8'h53;
      send_bit;
      check("dual rail", 8'h42, {txLinePos, txLineNeg});
      $display("test_tx_line done");
   endtask

   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst_n, configSourceSelect, registerResetPin} = 3'h3;
      {hwRail, hwRxOff, hwE3Ch1, hwE3Ch0} = 4'h0;
      {txOutputLevelSelect, txAllOnesSend, rxEqualizerEnable, txDriverOff} = 16'h0000;
      {remoteLoopback, localLoopback, sonetVsT3Select, eRateSelect} = 14'h0000;
      {txBitStrobe, txPosIn, txNegIn} = 12'h000;
      {rxSlicePos, rxSliceNeg, rxSliceClk} = 12'h000;
      chanStatus = 20'hA5C3E;
      fails = 0;
      n_compared = 0;
      step(12);
      rst_n = 1'h1;
      step(8);
      test_defaults;
      test_host_write;
      test_host_pins;
      test_abort;
      test_hw_mode;
      test_tx_line;
      conclude;
   end

   // Watchdog
   initial begin
      #400000;
      fails++;
      conclude;
   end
endmodule // hhcs_config_select_test
